// ==== src/fsg_gate_branch_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsg_defines.svh"

module fsg_gate_branch_ctl (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`FSG_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Sequencer word execution
    input wire logic i_word_first,
    input wire logic i_word_last,
    input wire logic [`FSG_SEQ_AW-1:0] i_word_addr,
    input wire logic [7:0] i_count_field,
    input wire logic [`FSG_SEQ_AW-1:0] i_next_addr,
    input wire logic [`FSG_SEQ_AW-1:0] i_data_field_addr,
    input wire logic [2:0] i_cond_code,
    input wire logic i_seq_stopped,
    // Check and compare results
    input wire logic i_rg_ecc_term,
    input wire logic i_crc_err,
    input wire logic i_compare_bad,
    input wire logic i_defect_bit,
    input wire logic i_ecc_err_cur,
    input wire logic i_ecc_err_prev,
    input wire logic i_ecc_done,
    input wire logic i_end_of_track,
    input wire logic i_general_input_two,
    // Drive gates
    output logic o_write_gate,
    output logic o_read_gate,
    // Check logic selection
    output logic o_crc_select,
    output logic o_ecc_select,
    output logic o_freeze_ecc,
    // Branch decision
    output logic o_alt_valid,
    output logic [`FSG_SEQ_AW-1:0] o_alt_addr,
    output logic o_alt_stop
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [7:0] ctrl_mem [0:`FSG_WORDS-1];
    logic [7:0] sect_target_q, sect_count_q, react_branch_q, branch_addr_q;
    logic [15:0] remain_q;
    logic hw_corr_q;
    logic wg_q, rg_q;
    logic in2_prev_q, edge_flag_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic crc_sel_q, ecc_sel_q, freeze_q;
    logic alt_valid_q, alt_stop_q;
    logic [`FSG_SEQ_AW-1:0] alt_addr_q;

    // Index of an APB address, valid only if word-aligned
    function automatic logic [7:0] fsg_index(input logic [`FSG_ADDR_W-1:0] a);
        fsg_index = a[9:2];
    endfunction

    // True when the index falls in the control store window
    function automatic logic fsg_is_ctrl(input logic [7:0] idx);
        fsg_is_ctrl = (idx >= `FSG_IDX_CTRL_FIRST) && (idx <= `FSG_IDX_CTRL_LAST);
    endfunction

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    logic [7:0] idx;
    logic [4:0] slot;
    logic mapped;
    logic wr_now;
    assign idx = fsg_index(i_paddr);
    assign slot = 5'(idx - `FSG_IDX_CTRL_FIRST);
    assign wr_now = i_psel && i_penable && pready_q && i_pwrite && mapped;

    // Map check, unaligned or high addresses are unmapped
    always_comb begin
        mapped = (i_paddr[1:0] == 2'b00) && (i_paddr[`FSG_ADDR_W-1:10] == '0);
        if (mapped) begin
            mapped = fsg_is_ctrl(idx) || idx == `FSG_IDX_SECT_TARGET || idx == `FSG_IDX_SECT_COUNT
                || idx == `FSG_IDX_REACT_BRANCH || idx == `FSG_IDX_REMAIN_HI
                || idx == `FSG_IDX_REMAIN_LO || idx == `FSG_IDX_HW_CORR
                || idx == `FSG_IDX_BRANCH_ADDR || idx == `FSG_IDX_GATE_STATUS;
        end
    end

    // Read mux, narrow registers in the low byte
    logic [31:0] rd_val;
    always_comb begin
        rd_val = `FSG_RST_WORD;
        if (fsg_is_ctrl(idx)) begin
            rd_val[7:0] = ctrl_mem[slot];
        end else begin
            unique case (idx)
                `FSG_IDX_SECT_TARGET: rd_val[7:0] = sect_target_q;
                `FSG_IDX_SECT_COUNT: rd_val[7:0] = sect_count_q;
                `FSG_IDX_REACT_BRANCH: rd_val[7:0] = react_branch_q;
                `FSG_IDX_REMAIN_HI: rd_val[7:0] = remain_q[15:8];
                `FSG_IDX_REMAIN_LO: rd_val[7:0] = remain_q[7:0];
                `FSG_IDX_HW_CORR: rd_val[`FSG_HW_CORR_BIT] = hw_corr_q;
                `FSG_IDX_BRANCH_ADDR: rd_val[7:0] = branch_addr_q;
                `FSG_IDX_GATE_STATUS: begin
                    rd_val[`FSG_ST_WG_BIT] = wg_q;
                    rd_val[`FSG_ST_RG_BIT] = rg_q;
                    rd_val[`FSG_ST_EDGE_BIT] = edge_flag_q;
                end
                default: rd_val = `FSG_RST_WORD;
            endcase
        end
    end

    // No wait state: data latched in setup, ready in the first access cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `FSG_RST_WORD;
        end else if (i_psel && !i_penable) begin
            pready_q <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q <= (!i_pwrite && mapped) ? rd_val : `FSG_RST_WORD;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Control store, written by software only; no reset, plain RAM
    always_ff @(posedge i_ref_clk) begin
        if (wr_now && fsg_is_ctrl(idx)) begin
            ctrl_mem[slot] <= i_pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Current word fields
    // ------------------------------------------------------------------------
    logic [7:0] cw;
    fsg_pkg::fsg_gate_code_t gcode;
    logic alt_sel;
    assign cw = ctrl_mem[i_word_addr];
    assign gcode = fsg_pkg::fsg_gate_code_t'(cw[`FSG_CF_GATE_HI:`FSG_CF_GATE_LO]);
    assign alt_sel = cw[`FSG_CF_ALT_BIT];

    // ------------------------------------------------------------------------
    // Gate outputs
    // ------------------------------------------------------------------------
    // Stop has top priority so a halted sequencer never leaves a gate open
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wg_q <= 1'b0;
        end else if (i_seq_stopped) begin
            wg_q <= 1'b0;
        end else if (i_word_last && gcode == fsg_pkg::FSG_GC_WG_OFF) begin
            wg_q <= 1'b0;
        end else if (i_word_first && gcode == fsg_pkg::FSG_GC_WG_ON && !rg_q) begin
            wg_q <= 1'b1;
        end
    end

    // Read gate; code 00 falls through and holds both gates
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rg_q <= 1'b0;
        end else if (i_seq_stopped || i_ecc_done) begin
            rg_q <= 1'b0;
        end else if (i_word_first && gcode == fsg_pkg::FSG_GC_RG_ON && !wg_q) begin
            rg_q <= 1'b1;
        end
    end

    // CRC or ECC selection at the first count of a gate word without transfer
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            crc_sel_q <= 1'b0;
            ecc_sel_q <= 1'b0;
        end else if (i_word_first && !cw[`FSG_CF_XFER_BIT]
                     && (gcode == fsg_pkg::FSG_GC_WG_ON || gcode == fsg_pkg::FSG_GC_RG_ON)) begin
            crc_sel_q <= i_count_field[`FSG_CNT_CRC_BIT];
            ecc_sel_q <= !i_count_field[`FSG_CNT_CRC_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // General input two edge catcher
    // ------------------------------------------------------------------------
    logic in2_edge, edge_consume, consume_edge;
    assign in2_edge = i_general_input_two ^ in2_prev_q;

    // Sticky edge; a new edge wins over consumption in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            in2_prev_q <= 1'b0;
            edge_flag_q <= 1'b0;
        end else begin
            in2_prev_q <= i_general_input_two;
            if (in2_edge) begin
                edge_flag_q <= 1'b1;
            end else if (consume_edge) begin
                edge_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Alternate branch decision
    // ------------------------------------------------------------------------
    fsg_pkg::fsg_go_t go;
    logic cnt_update, freeze_now;
    logic good, ecc_bad, cnt_zero;
    assign good = !i_crc_err && !i_compare_bad;
    assign ecc_bad = hw_corr_q ? i_ecc_err_prev : i_ecc_err_cur;
    assign cnt_zero = (sect_count_q == 8'h00);

    always_comb begin
        go = fsg_pkg::FSG_GO_NEXT;
        cnt_update = 1'b0;
        freeze_now = 1'b0;
        edge_consume = 1'b0;
        if (i_rg_ecc_term) begin
            unique case (fsg_pkg::fsg_cond_t'(i_cond_code))
                fsg_pkg::FSG_AC_001, fsg_pkg::FSG_AC_010: begin
                    if (i_crc_err) begin
                        go = fsg_pkg::FSG_GO_STOP;
                    end else if (i_compare_bad) begin
                        go = fsg_pkg::FSG_GO_DATA;
                    end else if (i_defect_bit) begin
                        go = (i_cond_code == 3'b010) ? fsg_pkg::FSG_GO_REACT
                                                     : fsg_pkg::FSG_GO_STOP;
                    end
                end
                fsg_pkg::FSG_AC_011, fsg_pkg::FSG_AC_100: begin
                    if (!good) begin
                        go = fsg_pkg::FSG_GO_DATA;
                    end else if (i_defect_bit) begin
                        go = (i_cond_code == 3'b011) ? fsg_pkg::FSG_GO_STOP
                                                     : fsg_pkg::FSG_GO_REACT;
                    end
                end
                fsg_pkg::FSG_AC_101: begin
                    if (cnt_zero || ecc_bad) begin
                        go = fsg_pkg::FSG_GO_STOP;
                    end else begin
                        go = fsg_pkg::FSG_GO_DATA;
                        cnt_update = 1'b1;
                    end
                end
                default: go = fsg_pkg::FSG_GO_NEXT;
            endcase
        end else begin
            unique case (fsg_pkg::fsg_cond_t'(i_cond_code))
                fsg_pkg::FSG_AC_001: begin
                    if (remain_q != 16'h0000) begin
                        freeze_now = 1'b1;
                    end else begin
                        go = fsg_pkg::FSG_GO_BRREG;
                    end
                end
                fsg_pkg::FSG_AC_010: begin
                    if (!cnt_zero) begin
                        go = fsg_pkg::FSG_GO_DATA;
                        cnt_update = 1'b1;
                    end
                end
                fsg_pkg::FSG_AC_110: begin
                    edge_consume = 1'b1;
                    if (edge_flag_q) begin
                        go = fsg_pkg::FSG_GO_DATA;
                    end
                end
                default: go = fsg_pkg::FSG_GO_NEXT;
            endcase
        end
    end

    logic decide;
    assign decide = i_word_last && alt_sel && !i_seq_stopped;
    // Consumption only counts when the decision is really taken
    assign consume_edge = decide && edge_consume;

    // Registered decision at word completion
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            alt_valid_q <= 1'b0;
            alt_stop_q <= 1'b0;
            alt_addr_q <= '0;
            freeze_q <= 1'b0;
        end else begin
            alt_valid_q <= decide;
            if (decide) begin
                alt_stop_q <= (go == fsg_pkg::FSG_GO_STOP);
                freeze_q <= freeze_now;
                unique case (go)
                    fsg_pkg::FSG_GO_DATA: alt_addr_q <= i_data_field_addr;
                    fsg_pkg::FSG_GO_REACT: alt_addr_q <= react_branch_q[`FSG_SEQ_AW-1:0];
                    fsg_pkg::FSG_GO_BRREG: alt_addr_q <= branch_addr_q[`FSG_SEQ_AW-1:0];
                    fsg_pkg::FSG_GO_STOP: alt_addr_q <= i_next_addr;
                    default: alt_addr_q <= i_next_addr;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Software registers, hardware counting has priority over a write
    // ------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sect_target_q <= `FSG_RST_BYTE;
            sect_count_q <= `FSG_RST_BYTE;
        end else if (decide && cnt_update) begin
            sect_count_q <= 8'(sect_count_q - 8'h01);
            sect_target_q <= i_end_of_track ? `FSG_RST_BYTE : 8'(sect_target_q + 8'h01);
        end else if (wr_now) begin
            if (idx == `FSG_IDX_SECT_TARGET) sect_target_q <= i_pwdata[7:0];
            if (idx == `FSG_IDX_SECT_COUNT) sect_count_q <= i_pwdata[7:0];
        end
    end

    // Plain software registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            react_branch_q <= `FSG_RST_BYTE;
            branch_addr_q <= `FSG_RST_BYTE;
            remain_q <= 16'h0000;
            hw_corr_q <= 1'b0;
        end else if (wr_now) begin
            if (idx == `FSG_IDX_REACT_BRANCH) react_branch_q <= i_pwdata[7:0];
            if (idx == `FSG_IDX_BRANCH_ADDR) branch_addr_q <= i_pwdata[7:0];
            if (idx == `FSG_IDX_REMAIN_HI) remain_q[15:8] <= i_pwdata[7:0];
            if (idx == `FSG_IDX_REMAIN_LO) remain_q[7:0] <= i_pwdata[7:0];
            if (idx == `FSG_IDX_HW_CORR) hw_corr_q <= i_pwdata[`FSG_HW_CORR_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_write_gate = wg_q;
    assign o_read_gate = rg_q;
    assign o_crc_select = crc_sel_q;
    assign o_ecc_select = ecc_sel_q;
    assign o_freeze_ecc = freeze_q;
    assign o_alt_valid = alt_valid_q;
    assign o_alt_addr = alt_addr_q;
    assign o_alt_stop = alt_stop_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_wg_on_req;
        i_word_first && !i_word_last && gcode == fsg_pkg::FSG_GC_WG_ON && !rg_q && !i_seq_stopped;
    endsequence
    sequence s_rg_on_req;
        i_word_first && gcode == fsg_pkg::FSG_GC_RG_ON && !wg_q && !i_seq_stopped && !i_ecc_done;
    endsequence

    AST_HOLD: assert property (!i_word_first && !i_word_last && !i_seq_stopped && !i_ecc_done
        |=> $stable(wg_q) && $stable(rg_q)) else $error("gates moved without cause");
    AST_WG_ON: assert property (s_wg_on_req |=> o_write_gate)
        else $error("write gate not raised");
    AST_WG_BLOCK: assert property (!wg_q && rg_q |=> !wg_q)
        else $error("write gate raised over read gate");
    AST_RG_ON: assert property (s_rg_on_req |=> o_read_gate)
        else $error("read gate not raised");
    AST_RG_BLOCK: assert property (wg_q && !rg_q |=> !rg_q)
        else $error("read gate raised over write gate");
    AST_RG_DROP: assert property (i_seq_stopped || i_ecc_done |=> !o_read_gate)
        else $error("read gate not dropped");
    AST_WG_OFF: assert property (i_word_last && gcode == fsg_pkg::FSG_GC_WG_OFF |=> !o_write_gate)
        else $error("write gate not cleared");
    AST_WG_STOP: assert property (i_seq_stopped |=> !o_write_gate)
        else $error("write gate open while stopped");
    AST_EXCL: assert property (!(o_write_gate && o_read_gate))
        else $error("both gates high");
    AST_DECIDE: assert property (decide |=> o_alt_valid ##1 !o_alt_valid || $past(decide))
        else $error("decision pulse wrong");
    AST_CRC_STOP: assert property (decide && i_rg_ecc_term && i_cond_code == 3'b001 && i_crc_err
        |=> o_alt_stop) else $error("no stop on CRC error");
    AST_REACT: assert property (decide && i_rg_ecc_term && i_cond_code == 3'b010 && good && i_defect_bit
        |=> !o_alt_stop && o_alt_addr == $past(react_branch_q[4:0])) else $error("react branch");
    AST_CNT: assert property (decide && cnt_update && !wr_now
        |=> sect_count_q == 8'($past(sect_count_q) - 8'h01)) else $error("count not decremented");
    AST_FREEZE: assert property (decide && !i_rg_ecc_term && i_cond_code == 3'b001 && remain_q != 16'h0000
        |=> o_freeze_ecc && o_alt_addr == $past(i_next_addr)) else $error("freeze missing");
    AST_EDGE: assert property (decide && !i_rg_ecc_term && i_cond_code == 3'b110 && edge_flag_q
        |=> o_alt_addr == $past(i_data_field_addr)) else $error("edge branch missing");
    AST_PREADY: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("apb ready timing");

endmodule
`default_nettype wire

// ==== src/fsg_defines.svh ====
`ifndef FSG_DEFINES_SVH
`define FSG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define FSG_IDX_CTRL_FIRST 8'hA0
`define FSG_IDX_CTRL_LAST 8'hBE
`define FSG_IDX_SECT_TARGET 8'h6A
`define FSG_IDX_SECT_COUNT 8'h6B
`define FSG_IDX_REACT_BRANCH 8'h6C
`define FSG_IDX_REMAIN_HI 8'h6D
`define FSG_IDX_REMAIN_LO 8'h6E
`define FSG_IDX_HW_CORR 8'h71
`define FSG_IDX_BRANCH_ADDR 8'h78
`define FSG_IDX_GATE_STATUS 8'h7F

// ----------------------------------------------------------------------------
// Sizes and field positions
// ----------------------------------------------------------------------------
`define FSG_ADDR_W 12
`define FSG_WORDS 31
`define FSG_SEQ_AW 5
`define FSG_CF_GATE_HI 6
`define FSG_CF_GATE_LO 5
`define FSG_CF_ALT_BIT 7
`define FSG_CF_XFER_BIT 0
`define FSG_CNT_CRC_BIT 6
`define FSG_HW_CORR_BIT 0
`define FSG_ST_WG_BIT 0
`define FSG_ST_RG_BIT 1
`define FSG_ST_EDGE_BIT 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FSG_RST_BYTE 8'h00
`define FSG_RST_WORD 32'h0000_0000

`endif

// ==== src/fsg_pkg.sv ====
package fsg_pkg;

    // Gate control code in control field bits 6-5
    typedef enum logic [1:0] {
        FSG_GC_HOLD = 2'b00,
        FSG_GC_WG_ON = 2'b01,
        FSG_GC_RG_ON = 2'b10,
        FSG_GC_WG_OFF = 2'b11
    } fsg_gate_code_t;

    // Alternate branch condition code
    typedef enum logic [2:0] {
        FSG_AC_000 = 3'b000,
        FSG_AC_001 = 3'b001,
        FSG_AC_010 = 3'b010,
        FSG_AC_011 = 3'b011,
        FSG_AC_100 = 3'b100,
        FSG_AC_101 = 3'b101,
        FSG_AC_110 = 3'b110,
        FSG_AC_111 = 3'b111
    } fsg_cond_t;

    // Outcome of an alternate branch decision
    typedef enum logic [2:0] {
        FSG_GO_NEXT = 3'b000,
        FSG_GO_DATA = 3'b001,
        FSG_GO_REACT = 3'b010,
        FSG_GO_BRREG = 3'b011,
        FSG_GO_STOP = 3'b100
    } fsg_go_t;

endpackage

// ==== tb/fsg_drive_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Drive channel stand-in
// ----
module fsg_drive_model (
    // Clock, reset and gates
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_write_gate,
    input wire logic i_read_gate,
    // Sticky flag for the bench
    output logic o_overlap
);
    // Both gates at once would garble the head, so remember it
    always_ff @(posedge i_ref_clk) begin
        o_overlap <= i_rst_n && (o_overlap || (i_write_gate && i_read_gate));
    end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsg_defines.svh"
module testbench;
    // ----
    // Signals, named as the ports so that .* binds them
    // ----
    logic i_ref_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_word_first, i_word_last, i_seq_stopped;
    logic i_rg_ecc_term, i_crc_err, i_compare_bad, i_defect_bit, i_ecc_err_cur, i_ecc_err_prev, i_ecc_done;
    logic i_end_of_track, i_general_input_two, o_pready, o_pslverr, o_write_gate, o_read_gate, o_crc_select;
    logic o_ecc_select, o_freeze_ecc, o_alt_valid, o_alt_stop, se, overlap;
    logic [`FSG_ADDR_W-1:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [`FSG_SEQ_AW-1:0] i_word_addr, i_next_addr, i_data_field_addr, o_alt_addr;
    logic [7:0] i_count_field;
    logic [2:0] i_cond_code;
    // Case table: cond, term, crc, cmp, defect, eot, toggle, outcome
    logic [11:0] tv [17] = '{12'hB01, 12'hB11, 12'h382, 12'h341, 12'h322, 12'h722, 12'h741, 12'hF00,
        12'hC09, 12'hC00, 12'h800, 12'h401, 12'h400, 12'hB02, 12'h523, 12'h923, 12'h204};
    logic [4:0] ea [5] = '{5'h05, 5'h11, 5'h05, 5'h0A, 5'h1C};
    int err_count = 0;
    int n_compared = 0;

    fsg_gate_branch_ctl i_dut (.*);
    fsg_drive_model i_drive (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_write_gate(o_write_gate),
        .i_read_gate(o_read_gate), .o_overlap(overlap));

    // Free running clock
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // One APB transfer; waits on pready, never a fixed count
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_pready !== 1'b1);
        {rd, se} = {o_prdata, o_pslverr};
        chk("access cycles", 1, n);
        {i_psel, i_penable} <= 2'b00;
    endtask

    task automatic cs(input logic [4:0] a, input logic [7:0] b);
        apb(1'b1, 12'((`FSG_IDX_CTRL_FIRST + a) * 4), {24'h0, b});
    endtask

    // Flags: first, last, stopped, ecc done; one cycle each
    task automatic word(input logic [4:0] a, input logic [3:0] fl);
        @(posedge i_ref_clk);
        {i_word_addr, i_word_first, i_word_last, i_seq_stopped, i_ecc_done} <= {a, fl};
        @(posedge i_ref_clk);
        {i_word_first, i_word_last, i_seq_stopped, i_ecc_done} <= 4'h0;
        #1;
    endtask

    task automatic gchk(input logic [1:0] e);
        chk("gates", e, {o_write_gate, o_read_gate});
    endtask

    task automatic t_gate;
        cs(0, 8'h20);
        cs(1, 8'h40);
        cs(2, 8'h60);
        cs(3, 8'h00);
        apb(1'b0, 12'h004, 0);
        chk("slverr", 1, se);
        word(0, 4'h8);
        gchk(2'b10);
        chk("crcsel", 2'b10, {o_crc_select, o_ecc_select});
        word(1, 4'h8);
        gchk(2'b10);
        word(3, 4'hC);
        gchk(2'b10);
        chk("valid", 0, o_alt_valid);
        word(2, 4'h4);
        gchk(2'b00);
        @(posedge i_ref_clk) i_count_field <= 8'h00;
        word(1, 4'h8);
        gchk(2'b01);
        chk("eccsel", 2'b01, {o_crc_select, o_ecc_select});
        apb(1'b0, 12'h1FC, 0);
        chk("status", 2'b10, rd[1:0]);
        word(0, 4'h8);
        gchk(2'b01);
        word(3, 4'h1);
        gchk(2'b00);
        word(1, 4'h8);
        word(3, 4'h2);
        gchk(2'b00);
        word(0, 4'h8);
        gchk(2'b10);
        word(3, 4'h2);
        gchk(2'b00);
        $display("gate test done");
    endtask

    task automatic t_alt;
        cs(4, 8'h80);
        apb(1'b1, 12'h1AC, 3);
        apb(1'b1, 12'h1A8, 5);
        apb(1'b1, 12'h1B0, 32'h0A);
        apb(1'b1, 12'h1E0, 32'h1C);
        apb(1'b0, 12'h290, 0);
        chk("ctrl", 32'h80, rd);
        foreach (tv[k]) begin
            @(posedge i_ref_clk);
            {i_cond_code, i_rg_ecc_term, i_crc_err, i_compare_bad, i_defect_bit, i_end_of_track} <= tv[k][11:4];
            i_general_input_two <= i_general_input_two ^ tv[k][3];
            word(4, 4'hC);
            chk("valid", 1, o_alt_valid);
            chk("stop", tv[k][2:0] == 3'd2, o_alt_stop);
            chk("addr", ea[tv[k][2:0]], o_alt_addr);
        end
        apb(1'b0, 12'h1AC, 0);
        chk("count", 0, rd);
        apb(1'b0, 12'h1A8, 0);
        chk("target", 1, rd);
        apb(1'b1, 12'h1B8, 1);
        word(4, 4'hC);
        chk("freeze", 1, o_freeze_ecc);
        apb(1'b1, 12'h1AC, 2);
        apb(1'b1, 12'h1C4, 1);
        @(posedge i_ref_clk) {i_cond_code, i_rg_ecc_term, i_ecc_err_prev} <= {3'b101, 1'b1, 1'b1};
        word(4, 4'hC);
        chk("eccstop", 1, o_alt_stop);
        @(posedge i_ref_clk) {i_ecc_err_prev, i_ecc_err_cur} <= 2'b01;
        word(4, 4'hC);
        chk("eccprev", 0, o_alt_stop);
        chk("addr", 5'h11, o_alt_addr);
        $display("alt test done");
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence; inputs start quiet, reset held five cycles
    initial begin
        {i_rst_n, i_psel, i_penable, i_pwrite, i_word_first, i_word_last, i_seq_stopped, i_ecc_done} = '0;
        {i_rg_ecc_term, i_crc_err, i_compare_bad, i_defect_bit, i_ecc_err_cur, i_ecc_err_prev} = '0;
        {i_end_of_track, i_general_input_two, i_paddr, i_pwdata, i_word_addr, i_cond_code} = '0;
        {i_next_addr, i_data_field_addr, i_count_field} = {5'h05, 5'h11, 8'h40};
        repeat (5) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_gate();
        t_alt();
        chk("overlap", 0, overlap);
        summarize();
    end

    // Watchdog, far beyond the under two hundred cycles the tests need
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
